// [core/ccs_pkg.sv]
package ccs_pkg;
  localparam int NCH = 4;
  localparam int NPAR = 7;
  localparam logic [1:0] ETH_CH = 2'h3;
  localparam logic [2:0] PAR_CMD = 3'h0;
  localparam logic [2:0] PAR_SPD = 3'h2;
  localparam logic [2:0] PAR_FREQ = 3'h3;
  localparam logic [2:0] PAR_TRQ = 3'h4;
  localparam logic [2:0] PAR_PID = 3'h5;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_QUAL = 12'h004;
  localparam logic [11:0] OFF_INV = 12'h008;
  localparam logic [11:0] OFF_CHSEL = 12'h00c;
  localparam logic [11:0] OFF_TMO = 12'h010;
  localparam logic [11:0] OFF_FLDLY = 12'h014;
  localparam logic [11:0] OFF_FBK = 12'h018;
  localparam logic [11:0] OFF_STAT = 12'h01c;
  localparam logic [31:0] MSK_CTRL = 32'h0000000f;
  localparam logic [31:0] MSK_QUAL = 32'h0000007f;
  localparam logic [31:0] MSK_INV = 32'h7f7f7f7f;
  localparam logic [31:0] MSK_CHSEL = 32'h00000033;
  localparam logic [31:0] MSK_TMO = 32'h0000ffff;
  localparam logic [31:0] MSK_FLDLY = 32'h00ffffff;
  localparam logic [31:0] MSK_FBK = 32'h0000ffff;
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [31:0] RST_QUAL = 32'h0000006d;
  localparam logic [31:0] RST_INV = 32'h09090909;
  localparam logic [31:0] RST_CHSEL = 32'h00000000;
  localparam logic [31:0] RST_TMO = 32'h00000000;
  localparam logic [31:0] RST_FLDLY = 32'h00000000;
  localparam logic [31:0] RST_FBK = 32'h00000000;
  localparam int CT_CFG = 0;
  localparam int CT_REACT = 1;
  localparam int CT_MOTION = 3;
  localparam int ST_ARM = 0;
  localparam int ST_EN = 4;
  localparam int ST_CINT = 8;
  localparam int ST_ETHE = 9;
  localparam int ST_PERMIT = 10;
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int TICK_MS = 1;
  localparam int MS_CYC = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic [1:0] {REACT_FAULT, REACT_HOLD, REACT_FALLBACK, REACT_NONE} ccs_react_e;
  typedef enum logic [1:0] {FL_REMOTE, FL_LOCAL, FL_DELAY} ccs_fl_e;
  typedef struct packed {
    logic [1:0]  chan;
    logic [2:0]  param;
    logic [15:0] data;
    logic        single_reg;
  } ccs_wr_s;
  typedef struct packed {
    logic green;
    logic red;
  } ccs_led_s;
endpackage

// [core/ccs_supervisor.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_supervisor import ccs_pkg::*; #(
  parameter int BLINK_CYCLES = BLINK_CYC, // LED half period
  parameter int MS_CYCLES    = MS_CYC     // Timeout tick
) (
  input  wire logic        clk,                 // System clock
  input  wire logic        rst,                 // Async reset
  input  wire logic [11:0] s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Byte enables
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Response valid
  input  wire logic        s_axi_bready,        // Response ready
  input  wire logic [11:0] s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read valid
  input  wire logic        s_axi_rready,        // Read ready
  input  wire logic        wr_valid,            // Parameter write strobe
  input  wire ccs_wr_s     wr,                  // Parameter write
  input  wire logic [3:0]  chan_warn,           // Per-channel warning
  input  wire logic        eth_dup_addr,        // Address duplication
  input  wire logic        eth_fdr_err,         // Replacement procedure error
  input  wire logic        eth_overload,        // Bus overload
  input  wire logic        remote_mode,         // Drive in remote mode
  input  wire logic        final_comm_phase,    // Motion net at final phase
  input  wire logic        forced_local,        // Forced local active
  input  wire logic        local_run,           // Local run command
  input  wire logic        local_dir,           // Local direction, 1 reverse
  input  wire logic [15:0] local_reference,     // Local reference
  input  wire logic        major_err,           // Major error seen
  input  wire logic        minor_err,           // Minor error present
  input  wire logic        ip_valid,            // Address assigned
  input  wire logic        ip_dup,              // Duplicate address
  input  wire logic        conn_up,             // Command connection up
  input  wire logic        conn_lost,           // Command connection lost
  output ccs_led_s         module_status_led,   // Module status LED
  output ccs_led_s         network_status_led,  // Network status LED
  output logic [15:0]      active_control_word, // Control word in use
  output logic [15:0]      active_freq_reference, // 0.1 Hz units
  output logic [15:0]      active_speed_reference, // Speed reference
  output logic [15:0]      active_torque_reference, // 0.1 % units
  output logic [15:0]      pid_setpoint,        // PID setpoint
  output logic             start_permit,        // Motor may start
  output logic             net_comm_interruption_error, // Embedded net error
  output logic             comm_interrupt,      // Interruption flag
  output logic             fault_request,       // Reaction: fault
  output logic             hold_last,           // Reaction: hold
  output logic             use_fallback         // Reaction: fallback
);
  localparam int BW = $clog2(BLINK_CYCLES);
  localparam int MW = $clog2(MS_CYCLES);

  logic [31:0] ctrl_r, qual_r, inv_r, chsel_r, tmo_r, fldly_r, fbk_r;
  logic        aw_q, w_q, do_wr, clr_cint, clr_ethe;
  logic [11:0] aw_addr;
  logic [31:0] w_data, wd_m, stat_word, rd_word;
  logic [3:0]  w_strb;
  logic [15:0] store [NCH][NPAR];
  logic [NCH-1:0][NPAR-1:0] written;
  logic [NCH-1:0] armed, enabled, warn_all;
  logic [1:0]  cmd_ch, ref_ch;
  ccs_react_e  react;
  ccs_fl_e     fl_state;
  logic [23:0] dly_cnt;
  logic        fl_exit, sup_ok, evt, eth_warn, eth_tmo, ms_tick, net_ok;
  logic [MW-1:0] ms_cnt;
  logic [15:0] tmo_cnt;
  logic [BW-1:0] blink_cnt;
  logic        blink, major_seen;

  // Byte-lane merge for partial AXI writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{s[i]}};
    return (o & ~m) | (d & m);
  endfunction

  // Offsets that answer OKAY; everything else gets SLVERR
  function automatic logic reg_known(input logic [11:0] a);
    return a == OFF_CTRL || a == OFF_QUAL || a == OFF_INV || a == OFF_CHSEL ||
           a == OFF_TMO || a == OFF_FLDLY || a == OFF_FBK || a == OFF_STAT;
  endfunction

  // A parameter qualifies for arming when its mask bit is set
  function automatic logic qual(input logic [31:0] q, input logic [2:0] p);
    return q[p];
  endfunction

  assign cmd_ch = chsel_r[1:0];
  assign ref_ch = chsel_r[5:4];
  assign react  = ccs_react_e'(ctrl_r[CT_REACT +: 2]);

  // AXI write side: address and data taken independently, then one response
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign do_wr         = aw_q && w_q && !s_axi_bvalid;
  assign wd_m          = merge(32'h0, w_data, w_strb);
  assign clr_cint      = do_wr && aw_addr == OFF_STAT && wd_m[ST_CINT];
  assign clr_ethe      = do_wr && aw_addr == OFF_STAT && wd_m[ST_ETHE];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      aw_addr <= 12'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_q <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_q <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_known(aw_addr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; reserved bits are masked to read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= RST_CTRL;
      qual_r <= RST_QUAL;
      inv_r <= RST_INV;
      chsel_r <= RST_CHSEL;
      tmo_r <= RST_TMO;
      fldly_r <= RST_FLDLY;
      fbk_r <= RST_FBK;
    end else if (do_wr) begin
      case (aw_addr)
        OFF_CTRL:  ctrl_r <= merge(ctrl_r, w_data, w_strb) & MSK_CTRL;
        OFF_QUAL:  qual_r <= merge(qual_r, w_data, w_strb) & MSK_QUAL;
        OFF_INV:   inv_r <= merge(inv_r, w_data, w_strb) & MSK_INV;
        OFF_CHSEL: chsel_r <= merge(chsel_r, w_data, w_strb) & MSK_CHSEL;
        OFF_TMO:   tmo_r <= merge(tmo_r, w_data, w_strb) & MSK_TMO;
        OFF_FLDLY: fldly_r <= merge(fldly_r, w_data, w_strb) & MSK_FLDLY;
        OFF_FBK:   fbk_r <= merge(fbk_r, w_data, w_strb) & MSK_FBK;
        default:   ;
      endcase
    end
  end

  // Status word shows the supervisor's own state
  always_comb begin
    stat_word = 32'h0;
    stat_word[ST_ARM +: NCH] = armed;
    stat_word[ST_EN +: NCH] = enabled;
    stat_word[ST_CINT] = comm_interrupt;
    stat_word[ST_ETHE] = net_comm_interruption_error;
    stat_word[ST_PERMIT] = start_permit;
  end

  always_comb begin
    case (s_axi_araddr)
      OFF_CTRL:  rd_word = ctrl_r;
      OFF_QUAL:  rd_word = qual_r;
      OFF_INV:   rd_word = inv_r;
      OFF_CHSEL: rd_word = chsel_r;
      OFF_TMO:   rd_word = tmo_r;
      OFF_FLDLY: rd_word = fldly_r;
      OFF_FBK:   rd_word = fbk_r;
      OFF_STAT:  rd_word = stat_word;
      default:   rd_word = 32'h0;
    endcase
  end

  // AXI read side: one beat, data registered at the address handshake
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= reg_known(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Parameter store, one word per channel and parameter; no reset needed
  always_ff @(posedge clk) begin
    if (wr_valid) begin
      store[wr.chan][wr.param] <= wr.data;
    end else if (fl_exit) begin
      store[cmd_ch][PAR_CMD] <= {14'h0, local_run && local_dir,
                                 local_run && !local_dir};
      store[ref_ch][PAR_FREQ] <= local_reference;
    end
  end

  // Per-channel written, armed and enabled tracking
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [1:0] CH = 2'(c);
    logic [NPAR-1:0] wbits;
    logic            arm, hit;
    logic [NPAR-1:0] inv;
    assign hit = wr_valid && wr.chan == CH;
    assign inv = inv_r[c*8 +: NPAR];
    // Writes win over a warning in the same cycle; forced local holds all clear
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        wbits <= '0;
      end else if (fl_state == FL_LOCAL) begin
        wbits <= '0;
      end else begin
        wbits <= (warn_all[c] ? '0 : wbits) |
                 (hit ? NPAR'(1) << wr.param : '0);
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        arm <= 1'b0;
      end else if (hit && qual(qual_r, wr.param)) begin
        arm <= 1'b1;
      end
    end
    assign written[c] = wbits;
    assign armed[c] = arm;
    assign enabled[c] = |inv && &(wbits | ~inv);
  end

  // Millisecond tick for the control-word timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt <= '0;
    end else if (ms_cnt == MW'(MS_CYCLES - 1)) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end
  assign ms_tick = ms_cnt == MW'(MS_CYCLES - 1);

  // Embedded channel timeout; saturates so it never wraps back to quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmo_cnt <= 16'h0;
    end else if (wr_valid && wr.chan == ETH_CH && wr.param == PAR_CMD) begin
      tmo_cnt <= 16'h0;
    end else if (ms_tick && armed[ETH_CH] && tmo_cnt != 16'hffff) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end
  assign eth_tmo = tmo_r[15:0] != 16'h0 && armed[ETH_CH] && tmo_cnt >= tmo_r[15:0];
  assign eth_warn = eth_tmo || eth_dup_addr || eth_fdr_err || eth_overload;
  assign warn_all = chan_warn | (NCH'(eth_warn) << ETH_CH);

  // Sticky embedded network error; a new error beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      net_comm_interruption_error <= 1'b0;
    end else if (eth_warn) begin
      net_comm_interruption_error <= 1'b1;
    end else if (clr_ethe) begin
      net_comm_interruption_error <= 1'b0;
    end
  end

  // Forced local sequencing with programmable exit delay
  assign fl_exit = fl_state == FL_LOCAL && !forced_local;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fl_state <= FL_REMOTE;
      dly_cnt <= 24'h0;
    end else begin
      case (fl_state)
        FL_REMOTE: if (forced_local) fl_state <= FL_LOCAL;
        FL_LOCAL: begin
          if (!forced_local) begin
            fl_state <= FL_DELAY;
            dly_cnt <= 24'h0;
          end
        end
        FL_DELAY: begin
          if (forced_local) begin
            fl_state <= FL_LOCAL;
          end else if (dly_cnt >= fldly_r[23:0]) begin
            fl_state <= FL_REMOTE;
          end else begin
            dly_cnt <= dly_cnt + 1'b1;
          end
        end
        default: fl_state <= FL_REMOTE;
      endcase
    end
  end

  // Supervision gate: motion network only at final phase, never during delay
  assign sup_ok = remote_mode && (!ctrl_r[CT_MOTION] || final_comm_phase) &&
                  fl_state == FL_REMOTE;
  assign evt = sup_ok && |(warn_all & armed);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comm_interrupt <= 1'b0;
    end else if (evt) begin
      comm_interrupt <= 1'b1;
    end else if (clr_cint) begin
      comm_interrupt <= 1'b0;
    end
  end

  assign fault_request = comm_interrupt && react == REACT_FAULT;
  assign hold_last = comm_interrupt && react == REACT_HOLD;
  assign use_fallback = comm_interrupt && react == REACT_FALLBACK;
  assign net_ok = enabled[cmd_ch] && enabled[ref_ch] && fl_state == FL_REMOTE;

  // Start permission needs both active channels enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_permit <= 1'b0;
    end else begin
      start_permit <= net_ok && !fault_request;
    end
  end

  // Selected words; control word stays zero until fresh words arrived
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_control_word <= 16'h0;
      active_freq_reference <= 16'h0;
      active_speed_reference <= 16'h0;
      active_torque_reference <= 16'h0;
      pid_setpoint <= 16'h0;
    end else if (!hold_last) begin
      active_control_word <= net_ok ? store[cmd_ch][PAR_CMD] : 16'h0;
      active_freq_reference <= use_fallback ? fbk_r[15:0] :
                               store[ref_ch][PAR_FREQ];
      active_speed_reference <= store[ref_ch][PAR_SPD];
      active_torque_reference <= store[ref_ch][PAR_TRQ];
      pid_setpoint <= store[ref_ch][PAR_PID];
    end
  end

  // Blink divider shared by both LEDs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == BW'(BLINK_CYCLES - 1)) begin
      blink_cnt <= '0;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // A major error is not recoverable, so only reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      major_seen <= 1'b0;
    end else if (major_err) begin
      major_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_status_led <= '0;
    end else if (major_seen) begin
      module_status_led <= '{green: 1'b0, red: 1'b1};
    end else if (minor_err || comm_interrupt) begin
      module_status_led <= '{green: 1'b0, red: blink};
    end else if (!ctrl_r[CT_CFG]) begin
      module_status_led <= '{green: blink, red: 1'b0};
    end else begin
      module_status_led <= '{green: 1'b1, red: 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      network_status_led <= '0;
    end else if (ip_dup) begin
      network_status_led <= '{green: 1'b0, red: 1'b1};
    end else if (conn_lost || eth_tmo) begin
      network_status_led <= '{green: 1'b0, red: blink};
    end else if (conn_up) begin
      network_status_led <= '{green: 1'b1, red: 1'b0};
    end else begin
      network_status_led <= '{green: ip_valid && blink, red: 1'b0};
    end
  end

  // Checks
  arm_on_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_valid && qual(qual_r, wr.param) |=> armed[$past(wr.chan)])
    else $error("qualifying write did not arm channel");
  unarmed_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (warn_all & armed) == '0 && !clr_cint && !comm_interrupt |=> !comm_interrupt)
    else $error("interruption from unarmed channel");
  evt_sets_flag_a: assert property (@(posedge clk) disable iff (rst)
    evt |=> comm_interrupt)
    else $error("warning on armed channel lost");
  start_gate_a: assert property (@(posedge clk) disable iff (rst)
    start_permit |-> $past(enabled[cmd_ch] && enabled[ref_ch]))
    else $error("start permitted on disabled channel");
  local_clear_a: assert property (@(posedge clk) disable iff (rst)
    fl_state == FL_LOCAL |=> enabled == '0)
    else $error("channel enabled during forced local");
  delay_supp_a: assert property (@(posedge clk) disable iff (rst)
    fl_state != FL_REMOTE |-> !evt ##1 (fl_state != FL_DELAY || !$rose(comm_interrupt)))
    else $error("supervision during exit delay");
  major_led_a: assert property (@(posedge clk) disable iff (rst)
    major_err |=> ##1 (module_status_led.red && !module_status_led.green) [*3])
    else $error("major error not steady red");
  react_fault_a: assert property (@(posedge clk) disable iff (rst)
    $rose(comm_interrupt) && react == REACT_FAULT |=> !start_permit)
    else $error("fault reaction did not block start");
  eth_err_a: assert property (@(posedge clk) disable iff (rst)
    eth_warn |=> net_comm_interruption_error)
    else $error("embedded network error not raised");
  exit_wait_a: assert property (@(posedge clk) disable iff (rst)
    fl_exit |=> fl_state == FL_DELAY)
    else $error("forced local exit skipped delay");
endmodule // ccs_supervisor
`default_nettype wire

// [tb/ccs_plc_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_plc_model import ccs_pkg::*; (
  input  wire logic clk,      // System clock
  output var logic  wr_valid, // Write strobe
  output var ccs_wr_s wr      // Parameter write
);
  // Idle strobe low at start
  initial begin
    wr_valid = 1'h0;
    wr = '0;
  end
  // Reference and command written before operation is asked
  task automatic send(input logic [1:0] c, input logic [2:0] p, input logic [15:0] d);
    @(posedge clk);
    wr_valid <= 1'h1;
    wr <= '{chan: c, param: p, data: d, single_reg: 1'h1}; // Single-register write
    @(posedge clk);
    wr_valid <= 1'h0;
    wr <= ~wr; // Scramble so stale payload is never trusted
  endtask
endmodule // ccs_plc_model
`default_nettype wire

// [tb/comm_channel_supervisor_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module comm_channel_supervisor_bench import ccs_pkg::*; ;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, wr_valid, remote_mode = 0, forced_local = 0;
  logic eth_dup_addr = 0, eth_fdr_err = 0, eth_overload = 0, final_comm_phase = 0;
  logic local_run = 0, local_dir = 0, major_err = 0, minor_err = 0, ip_valid = 0;
  logic ip_dup = 0, conn_up = 0, conn_lost = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, start_permit, net_comm_interruption_error;
  logic comm_interrupt, fault_request, hold_last, use_fallback;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, chan_warn = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] local_reference = 0, active_control_word, active_freq_reference;
  logic [15:0] active_speed_reference, active_torque_reference, pid_setpoint;
  ccs_wr_s wr;
  ccs_led_s module_status_led, network_status_led, led_prev;
  int failures = 0, n_checks = 0;
  // Short blink and tick counts keep the run brief
  ccs_supervisor #(.BLINK_CYCLES(4), .MS_CYCLES(4)) i_ccs_supervisor (.*);
  ccs_plc_model i_ccs_plc_model (.clk(clk), .wr_valid(wr_valid), .wr(wr));
  initial forever #25 clk = ~clk;
  task end_of_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Let n edges land, then sample where outputs are settled
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One bus transfer; ready sampled mid-cycle equals what the next edge sees
  task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int k;
    logic ta, tw, tr, dn;
    logic [31:0] rd;
    logic [1:0] rs;
    dn = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (k = 0; k < 40 && !dn; k++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_arvalid <= 1'h0;
      if (dn) s_axi_bready <= 1'h0;
      if (dn) s_axi_rready <= 1'h0;
    end
    chk(32'(dn), 32'h1);
    if (!dn) end_of_test();
    chk(32'(rs), 32'(er));
    if (!w && er == 2'h0) chk(rd, d);
  endtask
  task t_reset;
    axi(1'h0, OFF_QUAL, RST_QUAL, 2'h0);
    axi(1'h0, OFF_INV, RST_INV, 2'h0);
    axi(1'h0, OFF_STAT, '0, 2'h0);
    axi(1'h0, 12'h020, '0, 2'h2);
    // Unconfigured after reset, so the module LED blinks green
    wt(1);
    led_prev = module_status_led;
    wt(4);
    chk(32'(module_status_led ^ led_prev), 32'h2);
    chk(32'(module_status_led.red), 32'h0);
  endtask
  // Half-written channel must not permit a start
  task t_enable;
    axi(1'h1, OFF_CTRL, 32'h1, 2'h0);
    i_ccs_plc_model.send(2'h0, PAR_CMD, 16'h0001);
    wt(3);
    chk(32'(start_permit), '0);
    i_ccs_plc_model.send(2'h0, PAR_FREQ, 16'h01f4);
    wt(3);
    chk(32'(active_freq_reference), 32'h1f4);
    chk(32'(active_control_word), 32'h1);
    i_ccs_plc_model.send(2'h0, PAR_TRQ, 16'h03e8);
    wt(3);
    chk(32'(active_torque_reference), 32'h3e8);
    axi(1'h0, OFF_STAT, 32'h411, 2'h0);
  endtask
  // Unarmed warning first, then the armed one
  task t_warn;
    @(posedge clk);
    remote_mode <= 1'h1;
    chan_warn <= 4'h2;
    wt(3);
    chk(32'(comm_interrupt), '0);
    @(posedge clk);
    chan_warn <= 4'h1;
    wt(3);
    chk(32'({comm_interrupt, fault_request}), 32'h3);
    axi(1'h0, OFF_STAT, 32'h101, 2'h0);
    @(posedge clk);
    chan_warn <= '0;
    axi(1'h1, OFF_STAT, 32'h100, 2'h0);
    axi(1'h0, OFF_STAT, 32'h001, 2'h0);
  endtask
  // Forced local clears enables; a warning inside the exit delay must stay quiet
  task t_local;
    axi(1'h1, OFF_FLDLY, 32'h8, 2'h0);
    i_ccs_plc_model.send(2'h0, PAR_CMD, 16'h0002);
    i_ccs_plc_model.send(2'h0, PAR_FREQ, 16'h0100);
    wt(3);
    chk(32'({start_permit, active_control_word}), 32'h10002);
    @(posedge clk);
    forced_local <= 1'h1;
    local_run <= 1'h1;
    local_reference <= 16'h0123;
    wt(3);
    chk(32'({start_permit, active_control_word}), 32'h0);
    @(posedge clk);
    forced_local <= 1'h0;
    wt(2);
    @(posedge clk);
    chan_warn <= 4'h1;
    wt(3);
    chk(32'({comm_interrupt, active_control_word}), 32'h0);
    chk(32'(active_freq_reference), 32'h123);
    @(posedge clk);
    chan_warn <= 4'h0;
    wt(8);
    i_ccs_plc_model.send(2'h0, PAR_CMD, 16'h0004);
    wt(3);
    chk(32'(start_permit), 32'h0);
    i_ccs_plc_model.send(2'h0, PAR_FREQ, 16'h0200);
    wt(3);
    chk(32'({start_permit, active_control_word}), 32'h10004);
  endtask
  // Control-word timeout on the embedded channel, then both flags cleared
  task t_eth;
    axi(1'h1, OFF_TMO, 32'h2, 2'h0);
    i_ccs_plc_model.send(ETH_CH, PAR_CMD, 16'h0001);
    wt(20);
    led_prev = network_status_led;
    wt(4);
    chk(32'({net_comm_interruption_error, comm_interrupt, fault_request}), 32'h7);
    chk(32'(network_status_led ^ led_prev), 32'h1);
    chk(32'(network_status_led.green), 32'h0);
    axi(1'h1, OFF_TMO, 32'h0, 2'h0);
    axi(1'h1, OFF_STAT, 32'h300, 2'h0);
    axi(1'h0, OFF_STAT, 32'h419, 2'h0);
  endtask
  // Module LED: steady green, red blink on minor error, steady red on major
  task t_led;
    wt(1);
    chk(32'(module_status_led), 32'h2);
    wt(4);
    chk(32'(module_status_led), 32'h2);
    @(posedge clk);
    minor_err <= 1'h1;
    wt(2);
    led_prev = module_status_led;
    wt(4);
    chk(32'(module_status_led ^ led_prev), 32'h1);
    chk(32'(module_status_led.green), 32'h0);
    @(posedge clk);
    major_err <= 1'h1;
    wt(3);
    chk(32'(module_status_led), 32'h1);
    wt(4);
    chk(32'(module_status_led), 32'h1);
  endtask
  // Reset held 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_enable();
    t_warn();
    t_local();
    t_eth();
    t_led();
    end_of_test();
  end
endmodule // comm_channel_supervisor_bench
`default_nettype wire
